// *** cptf_pkg.sv ***
package cptf_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [7:0] PMCS_OFS = 8'h90;
	localparam logic [7:0] TXBT_OFS = 8'h9C;
	localparam logic [7:0] ROMP_OFS = 8'hA0;
	localparam logic [7:0] STA0_OFS = 8'hA4;
	localparam logic [7:0] CTRL_OFS = 8'hE0;
	localparam logic [7:0] ISTS_OFS = 8'hE4;
	localparam logic [7:0] IMSK_OFS = 8'hE8;
	// power-management fields
	localparam int PM_WAKE_EN_BIT = 8;
	localparam logic [1:0] PS_D0 = 2'h0;
	localparam logic [1:0] PS_D1 = 2'h1;
	localparam logic [1:0] PS_D2 = 2'h2;
	localparam logic [1:0] PS_D3HOT = 2'h3;
	localparam logic [3:0] PS_SUPPORT_RST = 4'hF;
	// tx burst and timeout fields
	localparam int TB_CNT_LSB = 16;
	localparam int TB_CNT_W = 5;
	localparam int TB_TMO_W = 12;
	// rom port fields
	localparam int RP_A16SEL_BIT = 31;
	localparam int RP_REN_BIT = 27;
	localparam int RP_WEN_BIT = 26;
	localparam int RP_ADDR_LSB = 8;
	localparam int RP_ADDR_W = 17;
	localparam logic RP_A16SEL_RST = 1'b1;
	// control register bits
	localparam int CT_FOUR_LED_BIT = 0;
	localparam int CT_TXDEFER_EN_BIT = 1;
	localparam int CT_SPEED100_BIT = 2;
	// interrupt status bits
	localparam int IRQ_TXDONE = 0;
	localparam int IRQ_TXDEFER = 1;
	localparam int IRQ_ROMDONE = 2;
	localparam int IRQ_W = 3;
	// timing
	localparam int CLK_MHZ = 250;
	localparam int STEP100_NS = 2560;
	localparam int STEP10_NS = 25600;
	localparam int STEP100_CYC = STEP100_NS * CLK_MHZ / 1000;
	localparam int STEP10_CYC = STEP10_NS * CLK_MHZ / 1000;
	localparam int ROM_CYC = 8;
	localparam logic [2:0] RX_STOPPED = 3'h0;
endpackage

// *** cptf_regs.sv ***
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cptf_regs #(
	parameter int STEP100_CYCLES = cptf_pkg::STEP100_CYC,
	parameter int STEP10_CYCLES  = cptf_pkg::STEP10_CYC,
	parameter int ROM_CYCLES     = cptf_pkg::ROM_CYC
) (
	input  wire logic        MCLK_I,
	input  wire logic        ARST_N_I,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        WAKE_EVENT_I,
	input  wire logic [3:0]  PS_SUPPORTED_I,
	input  wire logic        TX_BURST_OK_I,
	input  wire logic        TX_START_I,
	input  wire logic [2:0]  RX_STATE_I,
	input  wire logic        SA_LOAD_I,
	input  wire logic [31:0] SA_LOAD_DATA_I,
	input  wire logic [7:0]  ROM_DATA_I,
	output logic      [16:0] ROM_ADDR_O,
	output logic      [7:0]  ROM_DATA_O,
	output logic             ROM_DATA_OE_O,
	output logic             ROM_CE_N_O,
	output logic             ROM_OE_N_O,
	output logic             ROM_WE_N_O,
	output logic             SHARED_PIN_O,
	output logic             WAKE_N_O,
	output logic [1:0]       POWER_STATE_O,
	output logic             IRQ_O
);
	import cptf_pkg::*;

	typedef enum logic [1:0] {RP_IDLE, RP_READ, RP_WRITE} cptf_rom_type;

	typedef struct packed {
		logic [31:0]       dat;
		logic              ack;
		logic [1:0]        pstate;
		logic              wake_en;
		logic              wake_pend;
		logic [4:0]        burst_cfg;
		logic [11:0]       tmo_cfg;
		logic [4:0]        burst_cnt;
		logic [11:0]       tmo_cnt;
		logic [15:0]       step_cnt;
		logic              tmo_run;
		logic              a16sel;
		logic              ren;
		logic              wen;
		logic [16:0]       raddr;
		logic [7:0]        rdata;
		cptf_rom_type      rstate;
		logic [7:0]        rcnt;
		logic [31:0]       sta;
		logic [2:0]        ctrl;
		logic [IRQ_W-1:0]  ists;
		logic [IRQ_W-1:0]  imsk;
		logic              rom_oe;
		logic              rom_we;
		logic              shared;
		logic              irq;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              wake_n;
	} cptf_state_type;

	cptf_state_type s_reg;
	cptf_state_type s_next;

	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] nw,
	                                      input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic        req;
	logic        wr;
	logic [31:0] w;
	logic [31:0] rd;
	logic [15:0] step_len;
	logic [IRQ_W-1:0] ev;

	always_comb begin
		req = WB_CYC_I && WB_STB_I && !s_reg.ack;
		wr = req && WB_WE_I;
		w = 32'h0;
		rd = 32'h0;
		ev = '0;
		s_next = s_reg;
		s_next.ack = req;
		step_len = s_reg.ctrl[CT_SPEED100_BIT] ?
			16'(STEP100_CYCLES - 1) : 16'(STEP10_CYCLES - 1);
		case (WB_ADR_I)
			PMCS_OFS: begin
				rd[PM_WAKE_EN_BIT] = s_reg.wake_en;
				rd[1:0] = s_reg.pstate;
			end
			TXBT_OFS: begin
				rd[TB_CNT_LSB +: TB_CNT_W] = s_reg.burst_cfg;
				rd[TB_TMO_W-1:0] = s_reg.tmo_cfg;
			end
			ROMP_OFS: begin
				rd[RP_A16SEL_BIT] = s_reg.a16sel;
				rd[RP_REN_BIT] = s_reg.ren;
				rd[RP_WEN_BIT] = s_reg.wen;
				rd[RP_ADDR_LSB +: RP_ADDR_W] = s_reg.raddr;
				rd[7:0] = s_reg.rdata;
			end
			STA0_OFS: rd = s_reg.sta;
			CTRL_OFS: rd[2:0] = s_reg.ctrl;
			ISTS_OFS: rd[IRQ_W-1:0] = s_reg.ists;
			IMSK_OFS: rd[IRQ_W-1:0] = s_reg.imsk;
			default: rd = 32'h0;
		endcase
		if (req && !WB_WE_I) begin
			s_next.dat = rd;
		end
		if (wr) begin
			case (WB_ADR_I)
				PMCS_OFS: begin
					w = merge({23'h0, s_reg.wake_en, 6'h0, s_reg.pstate},
						WB_DAT_I, WB_SEL_I);
					s_next.wake_en = w[PM_WAKE_EN_BIT];
					if (PS_SUPPORTED_I[w[1:0]]) begin
						s_next.pstate = w[1:0];
					end // else discarded, bus still acked
				end
				TXBT_OFS: begin
					w = merge({11'h0, s_reg.burst_cfg, 4'h0, s_reg.tmo_cfg},
						WB_DAT_I, WB_SEL_I);
					s_next.burst_cfg = w[TB_CNT_LSB +: TB_CNT_W];
					s_next.tmo_cfg = w[TB_TMO_W-1:0];
					s_next.burst_cnt = 5'h0;
				end
				ROMP_OFS: begin
					w = merge(rd, WB_DAT_I, WB_SEL_I);
					s_next.a16sel = w[RP_A16SEL_BIT];
					if (s_reg.rstate == RP_IDLE) begin
						s_next.raddr = w[RP_ADDR_LSB +: RP_ADDR_W];
						s_next.rdata = w[7:0];
						s_next.ren = w[RP_REN_BIT];
						s_next.wen = w[RP_WEN_BIT] && !w[RP_REN_BIT];
					end
				end
				STA0_OFS: begin
					if (RX_STATE_I == RX_STOPPED) begin
						s_next.sta = merge(s_reg.sta, WB_DAT_I, WB_SEL_I);
					end
				end
				CTRL_OFS: begin
					// only the low control bits exist; the rest is dropped
					w = merge({29'h0, s_reg.ctrl}, WB_DAT_I, WB_SEL_I);
					s_next.ctrl = w[2:0];
				end
				IMSK_OFS: begin
					// mask shares the status layout
					w = merge({29'h0, s_reg.imsk}, WB_DAT_I, WB_SEL_I);
					s_next.imsk = w[IRQ_W-1:0];
				end
				default: ;
			endcase
		end
		if (SA_LOAD_I) begin
			s_next.sta = SA_LOAD_DATA_I;
		end
		// burst counter: event once programmed count of good writes is done
		if (TX_BURST_OK_I) begin
			if (s_reg.burst_cnt + 5'h1 >= s_reg.burst_cfg) begin
				s_next.burst_cnt = 5'h0;
				ev[IRQ_TXDONE] = 1'b1;
			end else begin
				s_next.burst_cnt = s_reg.burst_cnt + 5'h1;
			end
		end
		// defer timer restarts on each transmit start
		if (TX_START_I || !s_reg.ctrl[CT_TXDEFER_EN_BIT]) begin
			s_next.tmo_cnt = s_reg.tmo_cfg;
			s_next.step_cnt = 16'h0;
			s_next.tmo_run = TX_START_I && s_reg.ctrl[CT_TXDEFER_EN_BIT];
		end else if (s_reg.tmo_run) begin
			if (s_reg.step_cnt >= step_len) begin
				s_next.step_cnt = 16'h0;
				if (s_reg.tmo_cnt <= 12'h1) begin
					s_next.tmo_cnt = 12'h0;
					s_next.tmo_run = 1'b0;
					ev[IRQ_TXDEFER] = 1'b1;
				end else begin
					s_next.tmo_cnt = s_reg.tmo_cnt - 12'h1;
				end
			end else begin
				s_next.step_cnt = s_reg.step_cnt + 16'h1;
			end
		end
		// rom access sequencer
		case (s_reg.rstate)
			RP_IDLE: begin
				s_next.rcnt = 8'h0;
				if (s_reg.ren) begin
					s_next.rstate = RP_READ;
					s_next.rom_oe = 1'b1;
				end else if (s_reg.wen) begin
					s_next.rstate = RP_WRITE;
					s_next.rom_we = 1'b1;
				end
			end
			RP_READ, RP_WRITE: begin
				s_next.rcnt = s_reg.rcnt + 8'h1;
				if (s_reg.rcnt >= 8'(ROM_CYCLES - 1)) begin
					if (s_reg.rstate == RP_READ) begin
						s_next.rdata = ROM_DATA_I;
						s_next.ren = 1'b0;
					end else begin
						s_next.wen = 1'b0;
					end
					s_next.rom_oe = 1'b0;
					s_next.rom_we = 1'b0;
					s_next.rstate = RP_IDLE;
					ev[IRQ_ROMDONE] = 1'b1;
				end
			end
			default: s_next.rstate = RP_IDLE;
		endcase
		// wake pending follows events, cleared when leaving enable
		if (WAKE_EVENT_I && s_reg.wake_en) begin
			s_next.wake_pend = 1'b1;
		end else if (!s_next.wake_en) begin
			s_next.wake_pend = 1'b0;
		end
		// write-one-to-clear; a same-cycle event wins
		if (wr && WB_ADR_I == ISTS_OFS && WB_SEL_I[0]) begin
			s_next.ists = s_reg.ists & ~WB_DAT_I[IRQ_W-1:0];
		end
		s_next.ists = s_next.ists | ev;
		s_next.irq = |(s_next.ists & s_next.imsk);
		s_next.shared = (s_next.ctrl[CT_FOUR_LED_BIT] && s_next.a16sel) ?
			s_next.raddr[16] : 1'b0;
		// active-low pins kept as registers so each pin leaves a flip-flop
		s_next.ce_n = !(s_next.rom_oe || s_next.rom_we);
		s_next.oe_n = !s_next.rom_oe;
		s_next.we_n = !s_next.rom_we;
		s_next.wake_n = !(s_next.wake_pend && s_next.wake_en);
	end

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			s_reg <= '0;
			s_reg.a16sel <= RP_A16SEL_RST;
			s_reg.pstate <= PS_D0;
			s_reg.rstate <= RP_IDLE;
			// strobes and wake idle high through reset
			s_reg.ce_n <= 1'b1;
			s_reg.oe_n <= 1'b1;
			s_reg.we_n <= 1'b1;
			s_reg.wake_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// led function of the shared pin reads as low; its source is outside
	assign WB_DAT_O = s_reg.dat;
	assign WB_ACK_O = s_reg.ack;
	assign ROM_ADDR_O = s_reg.raddr;
	assign ROM_DATA_O = s_reg.rdata;
	assign ROM_DATA_OE_O = s_reg.rom_we;
	assign ROM_CE_N_O = s_reg.ce_n;
	assign ROM_OE_N_O = s_reg.oe_n;
	assign ROM_WE_N_O = s_reg.we_n;
	assign SHARED_PIN_O = s_reg.shared;
	assign WAKE_N_O = s_reg.wake_n;
	assign POWER_STATE_O = s_reg.pstate;
	assign IRQ_O = s_reg.irq;
endmodule
`default_nettype wire

// *** cptf_regs_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module cptf_regs_chk #(
	parameter int ROM_CYCLES = 8
) (
	input wire logic        MCLK_I,
	input wire logic        ARST_N_I,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic        WB_ACK_O,
	input wire logic [3:0]  PS_SUPPORTED_I,
	input wire logic [16:0] ROM_ADDR_O,
	input wire logic        ROM_DATA_OE_O,
	input wire logic        ROM_CE_N_O,
	input wire logic        ROM_WE_N_O,
	input wire logic        SHARED_PIN_O,
	input wire logic        WAKE_N_O,
	input wire logic [1:0]  POWER_STATE_O
);
	import cptf_pkg::*;
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!ARST_N_I);
	logic wen_q;
	int   ce_cnt;
	// shadow of the wake enable, taken from the host write itself
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			wen_q <= 1'b0;
			ce_cnt <= 0;
		end else begin
			ce_cnt <= ROM_CE_N_O ? 0 : ce_cnt + 1;
			if (WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == PMCS_OFS) begin
				wen_q <= WB_DAT_I[PM_WAKE_EN_BIT];
			end
		end
	end
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	ack_take_a: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
		else $error("ack not one cycle after request");
	wake_gate_a: assert property (!WAKE_N_O |-> wen_q || $past(wen_q))
		else $error("wake asserted while disabled");
	pstate_legal_a: assert property ($changed(POWER_STATE_O) |->
		PS_SUPPORTED_I[POWER_STATE_O] && $past(WB_STB_I && WB_WE_I))
		else $error("power state moved without a legal write");
	rom_len_a: assert property ($rose(ROM_CE_N_O) |-> ce_cnt == ROM_CYCLES)
		else $error("rom strobe length wrong");
	addr_hold_a: assert property (!ROM_CE_N_O && $past(!ROM_CE_N_O)
		|-> $stable(ROM_ADDR_O))
		else $error("rom address moved during access");
	wdata_drive_a: assert property (!ROM_WE_N_O |-> ROM_DATA_OE_O)
		else $error("rom write strobe without data drive");
	pin_a16_a: assert property (SHARED_PIN_O |->
		ROM_ADDR_O[16] || $past(ROM_ADDR_O[16]))
		else $error("shared pin high without address bit 16");
endmodule
bind cptf_regs cptf_regs_chk #(.ROM_CYCLES(ROM_CYCLES)) u_chk (
	.MCLK_I        (MCLK_I),
	.ARST_N_I      (ARST_N_I),
	.WB_CYC_I      (WB_CYC_I),
	.WB_STB_I      (WB_STB_I),
	.WB_WE_I       (WB_WE_I),
	.WB_ADR_I      (WB_ADR_I),
	.WB_DAT_I      (WB_DAT_I),
	.WB_ACK_O      (WB_ACK_O),
	.PS_SUPPORTED_I(PS_SUPPORTED_I),
	.ROM_ADDR_O    (ROM_ADDR_O),
	.ROM_DATA_OE_O (ROM_DATA_OE_O),
	.ROM_CE_N_O    (ROM_CE_N_O),
	.ROM_WE_N_O    (ROM_WE_N_O),
	.SHARED_PIN_O  (SHARED_PIN_O),
	.WAKE_N_O      (WAKE_N_O),
	.POWER_STATE_O (POWER_STATE_O)
);
`default_nettype wire

// *** cptf_flash.sv ***
`timescale 1ns/10ps
`default_nettype none
module cptf_flash (
	input  wire logic [16:0] addr_i,
	input  wire logic [7:0]  data_i,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	output logic      [7:0]  data_o
);
	logic [7:0] mem [0:255];
	logic [7:0] last;
	initial begin
		last = 8'h00;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
	end
	// byte stored at the trailing edge of the write strobe
	// the strobe leaving unknown at reset is no write
	always @(posedge we_n_i) begin
		if ($time > 0) begin
			mem[addr_i[7:0]] = data_i;
		end
	end
	// released bus shows the inverse of the last byte, never a stale match
	always @(ce_n_i, oe_n_i, addr_i) begin
		if (!ce_n_i && !oe_n_i) begin
			data_o = mem[addr_i[7:0]];
			last = data_o;
		end else begin
			data_o = ~last;
		end
	end
endmodule
`default_nettype wire

// *** cptf_regs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module cptf_regs_tb;
	import cptf_pkg::*;
	logic        MCLK_I, ARST_N_I, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
	logic [7:0]  WB_ADR_I, ROM_DATA_I, ROM_DATA_O;
	logic [3:0]  WB_SEL_I, PS_SUPPORTED_I, pls;
	logic [31:0] WB_DAT_I, WB_DAT_O, SA_LOAD_DATA_I, r, x;
	logic [2:0]  RX_STATE_I;
	logic [16:0] ROM_ADDR_O, ea;
	logic [1:0]  POWER_STATE_O;
	logic        ROM_DATA_OE_O, ROM_CE_N_O, ROM_OE_N_O, ROM_WE_N_O;
	logic        SHARED_PIN_O, WAKE_N_O, IRQ_O;
	wire logic   WAKE_EVENT_I = pls[0];
	wire logic   TX_BURST_OK_I = pls[1];
	wire logic   TX_START_I = pls[2];
	wire logic   SA_LOAD_I = pls[3];
	int          fail_count, n_compared;
	// short steps keep the defer timer inside a brief run
	cptf_regs #(.STEP100_CYCLES(4), .STEP10_CYCLES(8)) dut (
		.MCLK_I        (MCLK_I),
		.ARST_N_I      (ARST_N_I),
		.WB_CYC_I      (WB_CYC_I),
		.WB_STB_I      (WB_STB_I),
		.WB_WE_I       (WB_WE_I),
		.WB_ADR_I      (WB_ADR_I),
		.WB_SEL_I      (WB_SEL_I),
		.WB_DAT_I      (WB_DAT_I),
		.WB_DAT_O      (WB_DAT_O),
		.WB_ACK_O      (WB_ACK_O),
		.WAKE_EVENT_I  (WAKE_EVENT_I),
		.PS_SUPPORTED_I(PS_SUPPORTED_I),
		.TX_BURST_OK_I (TX_BURST_OK_I),
		.TX_START_I    (TX_START_I),
		.RX_STATE_I    (RX_STATE_I),
		.SA_LOAD_I     (SA_LOAD_I),
		.SA_LOAD_DATA_I(SA_LOAD_DATA_I),
		.ROM_DATA_I    (ROM_DATA_I),
		.ROM_ADDR_O    (ROM_ADDR_O),
		.ROM_DATA_O    (ROM_DATA_O),
		.ROM_DATA_OE_O (ROM_DATA_OE_O),
		.ROM_CE_N_O    (ROM_CE_N_O),
		.ROM_OE_N_O    (ROM_OE_N_O),
		.ROM_WE_N_O    (ROM_WE_N_O),
		.SHARED_PIN_O  (SHARED_PIN_O),
		.WAKE_N_O      (WAKE_N_O),
		.POWER_STATE_O (POWER_STATE_O),
		.IRQ_O         (IRQ_O)
	);
	cptf_flash u_rom (.addr_i(ROM_ADDR_O), .data_i(ROM_DATA_O),
		.ce_n_i(ROM_CE_N_O), .oe_n_i(ROM_OE_N_O), .we_n_i(ROM_WE_N_O),
		.data_o(ROM_DATA_I));
	initial begin
		MCLK_I = 1'b0;
		forever #2 MCLK_I = ~MCLK_I;
	end
	function automatic logic [7:0] rom_val(input logic [16:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge MCLK_I);
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge MCLK_I);
		{WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'b11, w};
		WB_ADR_I <= a;
		WB_DAT_I <= d;
		for (i = 0; i < 50 && WB_ACK_O !== 1'b1; i++) @(posedge MCLK_I);
		if (i == 50) begin
			fail_count++;
			give_verdict();
		end
		r = WB_DAT_O;
		{WB_CYC_I, WB_STB_I} <= 2'b00;
	endtask
	task automatic pulse(input int b);
		@(posedge MCLK_I) pls[b] <= 1'b1;
		@(posedge MCLK_I) pls[b] <= 1'b0;
		tick(2);
	endtask
	// host waits for the enable bit to drop before the next access
	task automatic poll(input int b);
		int i;
		for (i = 0; i < 40; i++) begin
			wb(0, ROMP_OFS, 0);
			if (r[b] === 1'b0) break;
		end
		if (i == 40) begin
			fail_count++;
			give_verdict();
		end
	endtask
	initial begin
		{WB_CYC_I, WB_STB_I, WB_WE_I, ARST_N_I, pls} = '0;
		{WB_ADR_I, WB_DAT_I, SA_LOAD_DATA_I, RX_STATE_I} = '0;
		WB_SEL_I = 4'hF;
		PS_SUPPORTED_I = 4'hB;
		{fail_count, n_compared} = '0;
		void'($urandom(20));
		tick(6);
		ARST_N_I <= 1'b1;
		wb(0, ROMP_OFS, 0); chk("romp_rst", r, 32'h8000_0000);
		chk("rom_idle", {ROM_CE_N_O, ROM_OE_N_O, ROM_WE_N_O, ROM_DATA_OE_O},
			4'hE);
		wb(0, 8'hF0, 0); chk("unmapped", r, 0);
		wb(0, PMCS_OFS, 0); chk("pmcs_rst", r, 0);
		for (int s = 0; s < 4; s++) begin
			x = PS_SUPPORTED_I[s] ? 32'(s) : r;
			wb(1, PMCS_OFS, s);
			wb(0, PMCS_OFS, 0); chk("pstate", r, x);
			chk("pstate_pin", {30'h0, POWER_STATE_O}, x);
		end
		pulse(0); chk("wake_off", WAKE_N_O, 1);
		wb(1, PMCS_OFS, 32'h103); pulse(0); chk("wake_on", WAKE_N_O, 0);
		wb(1, PMCS_OFS, 3); tick(2); chk("wake_clr", WAKE_N_O, 1);
		ea = 17'($urandom);
		wb(1, ROMP_OFS, 32'h0800_0000 | ea << 8); poll(RP_REN_BIT);
		chk("rom_rd", r[24:0], {ea, rom_val(ea)});
		chk("rom_addr", ROM_ADDR_O, ea);
		wb(0, ISTS_OFS, 0); chk("rom_done", r, 4);
		chk("irq_masked", IRQ_O, 0);
		wb(1, IMSK_OFS, 4); tick(1); chk("irq_on", IRQ_O, 1);
		wb(1, ISTS_OFS, 4); tick(1); chk("irq_clr", IRQ_O, 0);
		x = $urandom & 32'hFF;
		wb(1, ROMP_OFS, 32'h0400_0000 | ea << 8 | x); poll(RP_WEN_BIT);
		wb(1, ROMP_OFS, 32'h0800_0000 | ea << 8); poll(RP_REN_BIT);
		chk("rom_wr", r[7:0], x);
		wb(1, CTRL_OFS, 1); wb(1, ROMP_OFS, 32'h8100_0000); tick(2);
		chk("pin_a16", SHARED_PIN_O, 1);
		wb(1, ROMP_OFS, 32'h0100_0000); tick(2);
		chk("pin_led", SHARED_PIN_O, 0);
		wb(1, ROMP_OFS, 32'h8100_0000); wb(1, CTRL_OFS, 0); tick(2);
		chk("pin_nofour", SHARED_PIN_O, 0);
		SA_LOAD_DATA_I <= $urandom; pulse(3);
		wb(0, STA0_OFS, 0); chk("sta_load", r, SA_LOAD_DATA_I);
		RX_STATE_I <= 3'h4; wb(1, STA0_OFS, ~SA_LOAD_DATA_I);
		wb(0, STA0_OFS, 0); chk("sta_lock", r, SA_LOAD_DATA_I);
		RX_STATE_I <= RX_STOPPED; wb(1, STA0_OFS, ~SA_LOAD_DATA_I);
		wb(0, STA0_OFS, 0); chk("sta_wr", r, ~SA_LOAD_DATA_I);
		wb(1, TXBT_OFS, 3 << TB_CNT_LSB); pulse(1); pulse(1);
		wb(0, ISTS_OFS, 0); chk("txd_early", r[IRQ_TXDONE], 0);
		pulse(1); wb(0, ISTS_OFS, 0); chk("txd", r[IRQ_TXDONE], 1);
		wb(1, CTRL_OFS, 6); wb(1, TXBT_OFS, 5); pulse(2); tick(6);
		wb(0, ISTS_OFS, 0); chk("defer_early", r[IRQ_TXDEFER], 0);
		tick(30);
		wb(0, ISTS_OFS, 0); chk("defer", r[IRQ_TXDEFER], 1);
		give_verdict();
	end
endmodule
`default_nettype wire
